/* hw/adcsf_device.sv */
// converter end: frame shifting, frame classification and state sequencing
`timescale 1ns/1ps
module adcsf_device #(
  parameter int unsigned POR_CYC = adcsf_pkg::TRST_POR_CYC
) (
  // system clock domain (conversion runs here)
  input wire logic i_clk,
  input wire logic i_rst,
  // link
  adcsf_if.device lnk,
  // user side
  input wire logic [31:0] i_sample,
  output logic o_cmd_valid,
  output logic [31:0] o_cmd,
  output logic [1:0] o_state,
  output logic o_reset_function_select
);
  localparam int W = adcsf_pkg::FRAME_BITS;

  // ---------------- link clock domain ----------------
  logic [5:0] edge_cnt;
  logic [W-1:0] in_sr;
  logic [W-1:0] out_sr;
  logic load_tgl_s;
  logic cs_q;

  // select low marks a frame; first capture edge after fall sees cs_q high
  always_ff @(posedge lnk.sclk or posedge lnk.convert_start_select_n) begin
    if (lnk.convert_start_select_n) begin
      cs_q <= 1'b1;
    end else begin
      cs_q <= 1'b0;
    end
  end

  // capture on rising sclk; counter restart on first edge of a frame
  always_ff @(posedge lnk.sclk) begin
    if (cs_q) begin
      edge_cnt <= 6'h01; // R01 R04
    end else if (edge_cnt != adcsf_pkg::CNT_SAT) begin
      edge_cnt <= edge_cnt + 6'h01; // R04 R23
    end
    in_sr <= {in_sr[W-2:0], lnk.sdi}; // R04 R09 R19 R24
  end

  // output word handed over in system domain, sampled on frame start
  logic [W-1:0] out_word;
  // launch on falling sclk; frame start edge is the select fall itself
  always_ff @(negedge lnk.sclk or negedge lnk.convert_start_select_n) begin
    if (!lnk.convert_start_select_n && lnk.sclk == 1'b0 && cs_q) begin
      out_sr <= out_word; // R02
    end else begin
      out_sr <= {out_sr[W-2:0], 1'b0}; // R05 R19
    end
  end

  assign lnk.serial_out_lane_zero = out_sr[W-1]; // R05
  // tri-state outside frames and during reset
  assign lnk.serial_out_lane_zero_oe_n =
    lnk.convert_start_select_n | ~o_state[0]; // R06 R15

  // ---------------- system clock domain ----------------
  logic [2:0] cs_sync;
  logic [2:0] rst_sync;
  adcsf_pkg::adcsf_state_t state;
  logic [adcsf_pkg::TIMER_W-1:0] timer;
  logic rsel;
  logic [W-1:0] next_out;
  logic ready;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_sync <= 3'h7;
      rst_sync <= 3'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], lnk.convert_start_select_n};
      rst_sync <= {rst_sync[1:0], lnk.rst_n};
    end
  end

  logic cs_rise;
  logic rst_low;
  // edges judged only on agreeing second/third stages
  logic cs_lvl;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_lvl <= 1'b1;
    end else if (cs_sync[1] == cs_sync[2]) begin
      cs_lvl <= cs_sync[2];
    end
  end
  assign cs_rise = (cs_sync[1] == cs_sync[2]) & cs_sync[2] & ~cs_lvl;
  assign rst_low = (rst_sync[1] == rst_sync[2]) & ~rst_sync[2];

  // command decode at frame end; counter settled since sclk idle
  logic cmd_ok;
  assign cmd_ok = edge_cnt >= adcsf_pkg::CNT_OPTIMAL; // R07 R08 R09

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= adcsf_pkg::ADCSF_ACQ; // R12
      timer <= '0;
      o_cmd_valid <= 1'b0;
      o_cmd <= adcsf_pkg::CMD_NOP;
      rsel <= 1'b0;
      next_out <= '0;
      ready <= 1'b1;
    end else begin
      o_cmd_valid <= 1'b0;
      unique case (state)
        adcsf_pkg::ADCSF_RESET: begin
          ready <= 1'b0; // R15
          if (rst_low) begin
            timer <= '0;
          end else if (timer == (rsel ? adcsf_pkg::TIMER_W'(
              adcsf_pkg::TRST_APP_CYC) : adcsf_pkg::TIMER_W'(POR_CYC))) begin
            state <= adcsf_pkg::ADCSF_ACQ; // R16 R17
            ready <= 1'b1; // R17
            // select bit kept while timing so the right delay applies
            rsel <= 1'b0; // R15 R16
          end else begin
            timer <= timer + 1'b1;
          end
        end
        adcsf_pkg::ADCSF_ACQ: begin
          if (rst_low) begin
            state <= adcsf_pkg::ADCSF_RESET; // R14
            timer <= '0;
            ready <= 1'b0;
          end else if (!cs_lvl) begin
            ready <= 1'b0; // R01
          end
          if (!rst_low && cs_rise) begin
            state <= adcsf_pkg::ADCSF_CONV; // R13 R21
            timer <= '0;
            ready <= 1'b0; // R06
            o_cmd_valid <= 1'b1;
            o_cmd <= cmd_ok ? in_sr : adcsf_pkg::CMD_NOP; // R03 R06 R08
            next_out <= i_sample; // R21
            if (cmd_ok && in_sr[adcsf_pkg::OP_HI:adcsf_pkg::OP_LO] ==
                adcsf_pkg::OP_HALF_WORD_READ_CMD) begin
              next_out <= {(in_sr[adcsf_pkg::ADDR_HI:adcsf_pkg::ADDR_LO] ==
                  {1'b0, adcsf_pkg::RPC_ADDR[7:1]}) ? {15'h0000, rsel} :
                  adcsf_pkg::RPC_DEFAULT, 16'h0000}; // R22
            end
            if (cmd_ok && in_sr[adcsf_pkg::OP_HI:adcsf_pkg::OP_LO] ==
                adcsf_pkg::OP_WRITE &&
                in_sr[adcsf_pkg::ADDR_HI:adcsf_pkg::ADDR_LO] ==
                {1'b0, adcsf_pkg::RPC_ADDR[7:1]}) begin
              rsel <= in_sr[adcsf_pkg::RSTSEL_BIT];
            end
          end
        end
        adcsf_pkg::ADCSF_CONV: begin
          // select edges ignored while converting
          if (timer == adcsf_pkg::TIMER_W'(adcsf_pkg::TCONV_CYC - 1)) begin
            state <= adcsf_pkg::ADCSF_ACQ; // R11 R12
            ready <= 1'b1;
          end else begin
            timer <= timer + 1'b1; // R11
          end
        end
      endcase
    end
  end

  // next-frame word is stable long before the select fall (host waits)
  assign out_word = next_out; // R10
  assign lnk.conversion_ready_indicator = ready;
  assign o_state = state;
  assign o_reset_function_select = rsel;
endmodule

/* hw/adcsf_host.sv */
// host end: frame generator with divided serial clock
`timescale 1ns/1ps
module adcsf_host (
  // system clock
  input wire logic i_clk,
  input wire logic i_rst,
  // link
  adcsf_if.host lnk,
  // user side
  input wire logic i_start,
  input wire logic [31:0] i_cmd,
  input wire logic [6:0] i_edges,
  input wire logic i_reset_req,
  output logic o_busy,
  output logic [31:0] o_rx,
  output logic o_rx_valid
);
  logic [2:0] ready_sync;
  logic [6:0] left;
  logic [31:0] tx;
  logic [1:0] div;
  logic active;
  logic waiting;
  logic cs_n;
  logic sclk;
  logic rst_n;
  logic sd;
  // pad bits go first so the last word of a long frame is the command
  localparam logic [6:0] EDGES = 7'(adcsf_pkg::FRAME_BITS);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ready_sync <= 3'h0;
    end else begin
      ready_sync <= {ready_sync[1:0], lnk.conversion_ready_indicator};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_n <= 1'b1; sclk <= 1'b0; rst_n <= 1'b1; active <= 1'b0;
      waiting <= 1'b0; left <= '0; tx <= '0; div <= '0;
      o_rx <= '0; o_rx_valid <= 1'b0; o_busy <= 1'b0; sd <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      rst_n <= ~i_reset_req; // R17
      if (active) begin
        div <= div + 2'h1;
        if (div == 2'h1 && left != 0) begin
          sclk <= 1'b1;
          o_rx <= {o_rx[30:0], lnk.serial_out_lane_zero};
          left <= left - 7'h01;
        end else if (div == 2'h3) begin
          sclk <= 1'b0;
          if (left < EDGES) begin
            tx <= {tx[30:0], 1'b0}; // R09
            sd <= tx[30];
          end else begin
            sd <= (left > EDGES) ? 1'b0 : tx[31]; // R09
          end
          if (left == 0) begin
            cs_n <= 1'b1; // R10
            active <= 1'b0;
            waiting <= 1'b1;
            o_rx_valid <= 1'b1;
          end
        end
      end else if (waiting) begin
        // wait for ready high in both sync stages before another frame
        if (!ready_sync[1] && !ready_sync[2]) begin
          waiting <= 1'b1;
        end
        if (ready_sync[1] && ready_sync[2] && cs_n) begin
          waiting <= 1'b0; // R10
          o_busy <= 1'b0;
        end
      end else if (i_reset_req || !rst_n) begin
        cs_n <= 1'b0; // R17
      end else if (!cs_n) begin
        cs_n <= 1'b1;
      end else if (i_start) begin
        cs_n <= 1'b0;
        active <= 1'b1;
        o_busy <= 1'b1;
        o_rx <= '0;
        tx <= i_cmd; // R09 R20
        sd <= (i_edges > EDGES) ? 1'b0 : i_cmd[31];
        left <= i_edges;
        div <= '0;
      end
    end
  end

  assign lnk.convert_start_select_n = cs_n;
  assign lnk.sclk = sclk;
  assign lnk.sdi = sd;
  assign lnk.rst_n = rst_n;
endmodule

/* hw/adcsf_if.sv */
// interface joining the host and device ends of the serial frame link
`timescale 1ns/1ps
interface adcsf_if;
  logic convert_start_select_n;
  logic sclk;
  logic sdi;
  logic rst_n;
  logic serial_out_lane_zero;
  logic serial_out_lane_zero_oe_n;
  logic conversion_ready_indicator;
  modport host (
    output convert_start_select_n, sclk, sdi, rst_n,
    input serial_out_lane_zero, serial_out_lane_zero_oe_n,
    input conversion_ready_indicator
  );
  modport device (
    input convert_start_select_n, sclk, sdi, rst_n,
    output serial_out_lane_zero, serial_out_lane_zero_oe_n,
    output conversion_ready_indicator
  );
endinterface

/* hw/adcsf_pkg.sv */
// constants and types shared by both ends of the converter serial frame link
// Behaviour
// [R01] frame start: ready low, edge counter cleared
// [R02] frame start loads output word into shifter
// [R03] frame start clears command holding register; code writes o_cmd only at frame end, CMD_NOP for short frames
// [R04] capture edge: count, shift input into lsb
// [R05] launch edge: shifter msb onto output lane
// [R06] frame end: tristate, hand over command, ready low
// [R07] exactly 32 edges: command accepted
// [R08] fewer edges: write discarded, frame is no-op
// [R09] long frame: last 32 bits are command
// [R10] host waits for ready before next frame
// [R11] conversion ignores select transitions until done
// [R12] conversion done returns to acquire
// [R13] select rise in acquire starts conversion
// [R14] reset pin low enters reset, asynchronous; code synchronizes the pin and enters reset from acquire only
// [R15] select bit one: application reset of registers
// [R16] select bit zero: power-on reset, longer settle
// [R17] release reset with select, clock low
// [R18] chained devices programmed identically by host
// [R19] chain: input to lsb, msb out lane zero
// [R20] host supplies 32 times N edges
// [R21] sample on rise, frame on fall, decode each
// [R22] half-word read returns 16 bits next frame
// [R23] edge counter saturates above 32
// [R24] input shifter keeps latest 32 bits
package adcsf_pkg;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_OPTIMAL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h21;
  localparam logic [FRAME_BITS-1:0] CMD_NOP = 32'h0000_0000;
  // command fields
  localparam int unsigned OP_HI = 31;
  localparam int unsigned OP_LO = 27;
  localparam logic [4:0] OP_HALF_WORD_READ_CMD = 5'h19;
  localparam logic [4:0] OP_WRITE = 5'h1a;
  localparam int unsigned ADDR_HI = 24;
  localparam int unsigned ADDR_LO = 17;
  localparam int unsigned DATA_HI = 15;
  // reset-function select bit position in the reset/power control word
  localparam int unsigned RSTSEL_BIT = 0;
  localparam logic [7:0] RPC_ADDR = 8'h04;
  localparam logic [15:0] RPC_DEFAULT = 16'h0000;
  // timing, in ns of the 40 MHz system clock
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned TCONV_NS = 1000;
  localparam int unsigned TCONV_CYC = TCONV_NS / CLK_NS;
  localparam int unsigned TRST_APP_NS = 2000;
  localparam int unsigned TRST_APP_CYC = (TRST_APP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TRST_POR_NS = 20000000;
  localparam int unsigned TRST_POR_CYC = (TRST_POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TIMER_W = 20;
  localparam int unsigned SCLK_DIV = 4;
  localparam int unsigned SYNC_LEN = 3;
  typedef enum logic [1:0] {ADCSF_RESET, ADCSF_ACQ, ADCSF_CONV} adcsf_state_t;
endpackage

/* tb/adc_serial_frame_control_tb_top.sv */
// self-checking bench joining host and device ends of the link
`timescale 1ns/1ps
module adc_serial_frame_control_tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic i_reset_req = 1'b0;
  logic [31:0] i_cmd = 32'h0;
  logic [6:0] i_edges = 7'h20;
  logic [31:0] i_sample = 32'h0;
  logic o_busy, o_rx_valid, o_cmd_valid, o_reset_function_select;
  logic [31:0] o_rx, o_cmd, got_cmd, got_rx, c, s;
  logic [1:0] o_state;
  logic got_valid = 1'b0;
  logic [31:0] pw = 32'h0;
  logic rs = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'h7629;
  int k, r;
  int ks[6] = '{32, 31, 1, 33, 40, 64};
  adcsf_if adcsf_if_i ();
  adcsf_host adcsf_host_i (.i_clk, .i_rst, .lnk(adcsf_if_i), .i_start,
    .i_cmd, .i_edges, .i_reset_req, .o_busy, .o_rx, .o_rx_valid);
  adcsf_device #(.POR_CYC(100)) adcsf_device_i (.i_clk, .i_rst,
    .lnk(adcsf_if_i), .i_sample, .o_cmd_valid, .o_cmd, .o_state,
    .o_reset_function_select);
  adcsf_monitor adcsf_monitor_i (.i_clk, .i_rst,
    .convert_start_select_n(adcsf_if_i.convert_start_select_n),
    .sclk(adcsf_if_i.sclk), .sdi(adcsf_if_i.sdi), .rst_n(adcsf_if_i.rst_n),
    .serial_out_lane_zero(adcsf_if_i.serial_out_lane_zero),
    .serial_out_lane_zero_oe_n(adcsf_if_i.serial_out_lane_zero_oe_n),
    .conversion_ready_indicator(adcsf_if_i.conversion_ready_indicator));
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_cmd_valid) begin
      got_cmd <= o_cmd;
      got_valid <= 1'b1;
    end
    if (o_rx_valid) got_rx <= o_rx;
  end
  // short frames keep only the leading bits of the word
  function logic [31:0] exp_rx(input logic [31:0] w, input int n);
    return (n >= 32) ? w : w >> (32 - n);
  endfunction
  // word shown in the next frame: read data or the sampled word
  function logic [31:0] exp_word(input logic [31:0] w, input int n,
      input logic [31:0] smp, input logic sel);
    if (n >= 32 && w[31:27] == adcsf_pkg::OP_HALF_WORD_READ_CMD)
      return {(w[24:17] == {1'b0, adcsf_pkg::RPC_ADDR[7:1]}) ?
        {15'h0000, sel} : 16'h0000, 16'h0000};
    return smp;
  endfunction
  function logic [31:0] exp_cmd(input logic [31:0] w, input int n);
    return (n < 32) ? adcsf_pkg::CMD_NOP : w;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_state(input logic [1:0] st);
    int i;
    for (i = 0; i < 3000 && o_state !== st; i++) @(posedge i_clk);
  endtask
  task frame(input logic [31:0] w, input int n, input logic [31:0] smp);
    int i;
    @(posedge i_clk);
    i_cmd <= w;
    i_edges <= n[6:0];
    i_sample <= smp;
    i_start <= 1'b1;
    got_valid <= 1'b0;
    @(posedge i_clk);
    i_start <= 1'b0;
    // next frame only once the device shows ready again
    for (i = 0; i < 3000 && !(got_valid === 1'b1 && o_busy === 1'b0 &&
         adcsf_if_i.conversion_ready_indicator === 1'b1); i++)
      @(posedge i_clk);
  endtask
  task wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    $display("[ERR] %0t run did not finish", $time);
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (300) @(posedge i_clk);
    check(32'(o_state), 32'(adcsf_pkg::ADCSF_ACQ));
    for (int i = 0; i < 26; i++) begin
      k = (i < 6) ? ks[i] : 1 + {$random(seed)} % 64;
      c = $random(seed);
      s = $random(seed);
      frame(c, k, s);
      check(got_cmd, exp_cmd(c, k));
      if (k <= 32) check(got_rx, exp_rx(pw, k));
      pw = exp_word(c, k, s, rs);
      if (k >= 32 && c[31:27] == adcsf_pkg::OP_WRITE &&
          c[24:17] == {1'b0, adcsf_pkg::RPC_ADDR[7:1]}) rs = c[0];
      check(32'(o_state), 32'(adcsf_pkg::ADCSF_ACQ));
    end
    $display("test frame lengths done");
    frame({adcsf_pkg::OP_WRITE, 3'h0, adcsf_pkg::RPC_ADDR, 16'h0001}, 32,
      32'h0);
    check(32'(o_reset_function_select), 32'h1);
    // first pass is an application reset, second a power-on reset
    for (r = 0; r < 2; r++) begin
      @(posedge i_clk);
      i_reset_req <= 1'b1;
      // pulse outlasts the three-stage filter
      repeat (4) @(posedge i_clk);
      i_reset_req <= 1'b0;
      wait_state(adcsf_pkg::ADCSF_RESET);
      check(32'(o_state), 32'(adcsf_pkg::ADCSF_RESET));
      wait_state(adcsf_pkg::ADCSF_ACQ);
      check(32'(o_state), 32'(adcsf_pkg::ADCSF_ACQ));
      check(32'(o_reset_function_select),
        32'(adcsf_pkg::RPC_DEFAULT[adcsf_pkg::RSTSEL_BIT]));
      repeat (300) @(posedge i_clk);
    end
    $display("test reset kinds done");
    wrap_up;
  end
endmodule

/* tb/adcsf_monitor.sv */
// checker for the signals of the serial frame link
`timescale 1ns/1ps
module adcsf_monitor (
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link
  input wire logic convert_start_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic rst_n,
  input wire logic serial_out_lane_zero,
  input wire logic serial_out_lane_zero_oe_n,
  input wire logic conversion_ready_indicator
);
  wire cs = convert_start_select_n;
  wire rdy = conversion_ready_indicator;
  wire oe_n = serial_out_lane_zero_oe_n;
  logic [7:0] quiet;
  // settle time after any reset, the device may still be leaving reset
  always_ff @(posedge i_clk) begin
    if (i_rst || !rst_n) quiet <= 8'h00;
    else if (quiet != 8'hff) quiet <= quiet + 8'h01;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst || !rst_n || quiet != 8'hff);
  sequence s_start; $fell(cs); endsequence
  sequence s_end; $rose(cs); endsequence
  sequence s_conv_done; ##[1:70] $rose(rdy); endsequence
  AST_START_RDY_LOW: assert property (s_start |-> ##[0:5] !rdy)
    else $error("ready not low at frame start");
  AST_START_DRIVE: assert property (s_start |-> ##[1:6] (!oe_n || cs))
    else $error("output lane not driven in frame");
  AST_END_TRISTATE: assert property (s_end |-> ##[0:5] oe_n)
    else $error("output lane driven after frame");
  AST_END_RDY_LOW: assert property (s_end |-> ##[0:5] !rdy ##1 !rdy[*8])
    else $error("ready high early in conversion");
  AST_CONV_DONE: assert property (s_end |-> s_conv_done)
    else $error("conversion did not finish in time");
  AST_HOST_WAITS: assert property (s_start |-> $past(rdy))
    else $error("frame started while busy");
  AST_SCLK_IDLE: assert property (cs && $past(cs) |-> !sclk)
    else $error("serial clock moves outside frame");
  AST_RST_ENTRY: assert property (disable iff (i_rst)
    $fell(rst_n) |-> ##[0:4] (!rdy && oe_n))
    else $error("reset did not quiet the link");
  AST_RST_EXIT: assert property (disable iff (i_rst)
    $rose(rst_n) |-> !cs && !sclk)
    else $error("reset released with select or clock high");
endmodule
